// file: hw/cifd_pkg.sv
// Shared constants, kinds and register map of the instruction field decoder
package cifd_pkg;

    // ==========================================================
    // Widths
    localparam int WORD_W = 16;
    localparam int PC_W   = 21;
    localparam int FILE_W = 12;
    localparam int F8_W   = 8;
    localparam int TBL_W  = 21;
    localparam int LAT_W  = 8;
    localparam int IDX_W  = 7;
    localparam int BIT_W  = 3;
    localparam int BANK_W = 4;

    // ==========================================================
    // Field positions inside an instruction word
    localparam int D_POS      = 9;
    localparam int A_POS      = 8;
    localparam int F_HI       = 7;
    localparam int BIT_HI     = 11;
    localparam int BIT_LO     = 9;
    localparam int LIT_HI     = 7;
    localparam int TAG_HI     = 15;
    localparam int TAG_LO     = 12;
    localparam int FS_HI      = 11;
    localparam int CALL_S_POS = 8;
    localparam int RET_S_POS  = 0;
    localparam int MODE_HI    = 1;
    localparam int BRL_HI     = 10;
    localparam int BRS_HI     = 7;
    localparam int IDX_HI     = 6;
    localparam int ABS_LO_HI  = 7;

    localparam logic [3:0]        SECOND_TAG  = 4'hF;
    localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;

    // ==========================================================
    // Table pointer modes
    localparam logic [1:0] TBL_KEEP     = 2'h0;
    localparam logic [1:0] TBL_POST_INC = 2'h1;
    localparam logic [1:0] TBL_POST_DEC = 2'h2;
    localparam logic [1:0] TBL_PRE_INC  = 2'h3;

    // ==========================================================
    // Instruction kinds, as classified by the core's opcode decode
    typedef enum logic [3:0] {
        KIND_BYTE, KIND_BIT, KIND_LIT, KIND_MOVE, KIND_CALL, KIND_GOTO,
        KIND_RET, KIND_BRA_LONG, KIND_BRA_SHORT, KIND_TBLRD, KIND_TBLWT,
        KIND_IDX_MOVE, KIND_OTHER
    } cifd_kind_t;

    typedef enum logic {ST_FIRST, ST_SECOND} cifd_phase_t;

    // ==========================================================
    // Register map
    localparam int              APB_AW      = 12;
    localparam logic [11:0]     REG_BANK    = 12'h000;
    localparam logic [11:0]     REG_PROGRAM_TABLE_POINTER  = 12'h004;
    localparam logic [11:0]     REG_TBLLAT  = 12'h008;
    localparam logic [11:0]     REG_STATUS  = 12'h00C;
    localparam logic [TBL_W-1:0] PROGRAM_TABLE_POINTER_RST = 21'h000000;
    localparam int              STAT_PEND   = 4;

endpackage : cifd_pkg

// file: hw/cifd_tbl_if.sv
// Link between the decoder and its table pointer unit
interface cifd_tbl_if;
    import cifd_pkg::*;
    logic             go;
    logic [1:0]       mode;
    logic             load;
    logic [TBL_W-1:0] load_val;
    logic [TBL_W-1:0] ptr;
    logic [TBL_W-1:0] access_addr;
    modport ctl  (output go, mode, load, load_val, input ptr, access_addr);
    modport unit (input go, mode, load, load_val, output ptr, access_addr);
endinterface : cifd_tbl_if

// file: hw/cifd_program_table_pointer.sv
// Program table pointer with its four access modes
module cifd_program_table_pointer
    import cifd_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    cifd_tbl_if.unit  t
);

    typedef struct packed {
        logic [TBL_W-1:0] ptr;
    } cifd_tp_state_t;

    cifd_tp_state_t r_reg;
    cifd_tp_state_t r_next;

    // ==========================================================
    // Next state
    always_comb begin
        r_next        = r_reg;
        t.ptr         = r_reg.ptr;
        t.access_addr = r_reg.ptr;
        if (t.go) begin
            case (t.mode)
                TBL_POST_INC: r_next.ptr = r_reg.ptr + TBL_W'(1); // [RQ9]
                TBL_POST_DEC: r_next.ptr = r_reg.ptr - TBL_W'(1); // [RQ9]
                TBL_PRE_INC: begin
                    r_next.ptr    = r_reg.ptr + TBL_W'(1); // [RQ9]
                    t.access_addr = r_reg.ptr + TBL_W'(1);
                end
                default: r_next.ptr = r_reg.ptr;
            endcase
        end
        // Software load wins so a reprogrammed pointer is never lost
        if (t.load) begin
            r_next.ptr = t.load_val; // [RQ8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg.ptr <= PROGRAM_TABLE_POINTER_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_post_inc_step: assert property (t.go && t.mode == TBL_POST_INC && !t.load // [RQ9]
        |=> r_reg.ptr == $past(r_reg.ptr) + TBL_W'(1))
        else $error("post increment did not step the pointer");
    a_pre_inc_addr: assert property (t.go && t.mode == TBL_PRE_INC // [RQ9]
        |-> t.access_addr == r_reg.ptr + TBL_W'(1))
        else $error("pre increment used the old pointer");
    a_keep_ptr: assert property (t.go && t.mode == TBL_KEEP && !t.load // [RQ9]
        |=> $stable(r_reg.ptr))
        else $error("unchanged mode moved the pointer");

endmodule : cifd_program_table_pointer

// file: hw/cifd_top.sv
// Operand field decoder for 16-bit instruction words, with APB register access
// What this block does
// (RQ1) Byte ops: opcode, destination, access, 8-bit file
// (RQ2) Destination 0 to accumulator, 1 to file
// (RQ3) Access 0 uses access bank, 1 selector bank
// (RQ4) Memory move: 12-bit source, then 1111 destination
// (RQ5) Bit ops: position 11..9, access bit, file
// (RQ6) Literal ops: opcode 15..8, constant 7..0
// (RQ7) Fast bit 1 saves or restores shadows
// (RQ8) 21-bit table pointer and 8-bit table latch
// (RQ9) Table modes: keep, post-inc, post-dec, pre-inc
// (RQ10) Relative branches add signed offset; others absolute
// (RQ11) Indexed moves carry 7-bit source, destination offsets
// (RQ12) Lone second word executes as no-operation
// (RQ13) Fields reach datapath from flops, the cycle after the word is taken
module cifd_top
    import cifd_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              instr_valid,
    input  wire logic [WORD_W-1:0] instr_word,
    input  wire cifd_kind_t        instr_kind,
    input  wire logic [PC_W-1:0]   instr_pc,
    input  wire logic              tbl_rd_ack,
    input  wire logic [LAT_W-1:0]  tbl_rd_data,
    output logic                   dec_valid,
    output logic                   dec_nop,
    output logic                   res_to_accum,
    output logic                   res_to_file,
    output logic                   bank_from_selector,
    output logic      [FILE_W-1:0] file_addr,
    output logic      [BIT_W-1:0]  bit_pos,
    output logic      [F8_W-1:0]   literal,
    output logic                   move_valid,
    output logic      [FILE_W-1:0] move_src,
    output logic      [FILE_W-1:0] move_dst,
    output logic                   shadow_save,
    output logic                   shadow_restore,
    output logic                   branch_valid,
    output logic      [PC_W-1:0]   branch_target,
    output logic                   idx_valid,
    output logic      [IDX_W-1:0]  source_index_offset,
    output logic      [IDX_W-1:0]  destination_index_offset,
    output logic                   tbl_rd_req,
    output logic                   tbl_wr_req,
    output logic      [TBL_W-1:0]  tbl_addr,
    output logic      [LAT_W-1:0]  table_byte_latch
);

    typedef struct packed {
        cifd_phase_t       phase;
        cifd_kind_t        held_kind;
        logic [WORD_W-1:0] held_word;
        cifd_kind_t        last_kind;
        logic [BANK_W-1:0] bank;
        logic [LAT_W-1:0]  latch;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              dec_valid;
        logic              dec_nop;
        logic              res_to_file;
        logic              res_to_accum;
        logic              bank_sel;
        logic [FILE_W-1:0] file_addr;
        logic [BIT_W-1:0]  bit_pos;
        logic [F8_W-1:0]   literal;
        logic              move_valid;
        logic [FILE_W-1:0] move_src;
        logic [FILE_W-1:0] move_dst;
        logic              shadow_save;
        logic              shadow_restore;
        logic              branch_valid;
        logic [PC_W-1:0]   branch_target;
        logic              idx_valid;
        logic [IDX_W-1:0]  src_idx;
        logic [IDX_W-1:0]  dst_idx;
        logic              tbl_rd_req;
        logic              tbl_wr_req;
        logic [TBL_W-1:0]  tbl_addr;
    } cifd_state_t;

    cifd_state_t r_reg;
    cifd_state_t r_next;
    cifd_tbl_if  tbl ();

    cifd_program_table_pointer u_program_table_pointer (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (tbl.unit)
    );

    // ==========================================================
    // Helpers
    function automatic logic cifd_mapped(input logic [APB_AW-1:0] a);
        return a == REG_BANK || a == REG_PROGRAM_TABLE_POINTER || a == REG_TBLLAT || a == REG_STATUS;
    endfunction : cifd_mapped

    function automatic logic cifd_is_second(input logic [WORD_W-1:0] w);
        return w[TAG_HI:TAG_LO] == SECOND_TAG;
    endfunction : cifd_is_second

    function automatic logic cifd_two_word(input cifd_kind_t k);
        return k == KIND_MOVE || k == KIND_CALL || k == KIND_GOTO || k == KIND_IDX_MOVE;
    endfunction : cifd_two_word

    logic apb_setup;
    logic apb_write;
    logic first_ok;

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && r_reg.pready && pwrite;
    assign first_ok  = instr_valid && r_reg.phase == ST_FIRST && !cifd_is_second(instr_word);

    // ==========================================================
    // Next state
    always_comb begin
        r_next                = r_reg;
        r_next.pready         = 1'b0;
        r_next.pslverr        = 1'b0;
        r_next.dec_valid      = 1'b0;
        r_next.dec_nop        = 1'b0;
        r_next.move_valid     = 1'b0;
        r_next.shadow_save    = 1'b0;
        r_next.shadow_restore = 1'b0;
        r_next.branch_valid   = 1'b0;
        r_next.idx_valid      = 1'b0;
        r_next.tbl_rd_req     = 1'b0;
        r_next.tbl_wr_req     = 1'b0;
        tbl.go                = 1'b0;
        tbl.mode              = instr_word[MODE_HI:0];
        tbl.load              = 1'b0;
        tbl.load_val          = pwdata[TBL_W-1:0];

        // Answer one cycle after setup, so pready and prdata come from flops
        if (apb_setup) begin
            r_next.pready  = 1'b1;
            r_next.pslverr = !cifd_mapped(paddr);
            r_next.prdata  = '0;
            if (paddr == REG_BANK) begin
                r_next.prdata[BANK_W-1:0] = r_reg.bank;
            end else if (paddr == REG_PROGRAM_TABLE_POINTER) begin
                r_next.prdata[TBL_W-1:0] = tbl.ptr; // [RQ8]
            end else if (paddr == REG_TBLLAT) begin
                r_next.prdata[LAT_W-1:0] = r_reg.latch; // [RQ8]
            end else if (paddr == REG_STATUS) begin
                r_next.prdata[3:0]       = r_reg.last_kind;
                r_next.prdata[STAT_PEND] = r_reg.phase == ST_SECOND;
            end
        end
        if (apb_write) begin
            if (paddr == REG_BANK) begin
                r_next.bank = pwdata[BANK_W-1:0]; // [RQ3]
            end else if (paddr == REG_PROGRAM_TABLE_POINTER) begin
                tbl.load = 1'b1; // [RQ8]
            end else if (paddr == REG_TBLLAT) begin
                r_next.latch = pwdata[LAT_W-1:0];
            end
        end
        // Fetched byte overrides a software write in the same cycle
        if (tbl_rd_ack) begin
            r_next.latch = tbl_rd_data; // [RQ8]
        end

        if (instr_valid) begin
            r_next.last_kind = instr_kind;
            case (r_reg.phase)
                ST_FIRST: begin
                    // Plain views of the word, taken for every first word; KIND_BIT then forces res_to_file
                    r_next.res_to_file = instr_word[D_POS]; // [RQ1] [RQ2] [RQ13]
                    r_next.bank_sel    = instr_word[A_POS]; // [RQ3]
                    r_next.file_addr   = {instr_word[A_POS] ? r_reg.bank : ACCESS_BANK,
                                          instr_word[F_HI:0]}; // [RQ1] [RQ3]
                    r_next.bit_pos     = instr_word[BIT_HI:BIT_LO]; // [RQ5]
                    r_next.literal     = instr_word[LIT_HI:0]; // [RQ6]
                    if (cifd_is_second(instr_word)) begin
                        r_next.dec_valid = 1'b1;
                        r_next.dec_nop   = 1'b1; // [RQ12]
                    end else if (cifd_two_word(instr_kind)) begin
                        r_next.held_word = instr_word;
                        r_next.held_kind = instr_kind;
                        r_next.phase     = ST_SECOND;
                    end else begin
                        r_next.dec_valid = 1'b1;
                        case (instr_kind)
                            KIND_BIT: r_next.res_to_file = 1'b1; // [RQ5]
                            KIND_RET: r_next.shadow_restore = instr_word[RET_S_POS]; // [RQ7]
                            KIND_BRA_LONG: begin
                                r_next.branch_valid  = 1'b1;
                                r_next.branch_target = instr_pc +
                                    {{(PC_W-BRL_HI-1){instr_word[BRL_HI]}},
                                     instr_word[BRL_HI:0]}; // [RQ10]
                            end
                            KIND_BRA_SHORT: begin
                                r_next.branch_valid  = 1'b1;
                                r_next.branch_target = instr_pc +
                                    {{(PC_W-BRS_HI-1){instr_word[BRS_HI]}},
                                     instr_word[BRS_HI:0]}; // [RQ10]
                            end
                            KIND_TBLRD, KIND_TBLWT: begin
                                tbl.go                = 1'b1; // [RQ9]
                                r_next.tbl_addr       = tbl.access_addr;
                                r_next.tbl_rd_req     = instr_kind == KIND_TBLRD;
                                r_next.tbl_wr_req     = instr_kind == KIND_TBLWT;
                            end
                            default: r_next.dec_nop = 1'b0;
                        endcase
                    end
                end
                ST_SECOND: begin
                    r_next.phase     = ST_FIRST;
                    r_next.dec_valid = 1'b1;
                    // A broken pair is dropped rather than guessed at
                    if (!cifd_is_second(instr_word)) begin
                        r_next.dec_nop = 1'b1;
                    end else begin
                        case (r_reg.held_kind)
                            KIND_MOVE: begin
                                r_next.move_valid = 1'b1;
                                r_next.move_src   = r_reg.held_word[FS_HI:0]; // [RQ4]
                                r_next.move_dst   = instr_word[FS_HI:0]; // [RQ4]
                            end
                            KIND_IDX_MOVE: begin
                                r_next.idx_valid = 1'b1;
                                r_next.src_idx   = r_reg.held_word[IDX_HI:0]; // [RQ11]
                                r_next.dst_idx   = instr_word[IDX_HI:0]; // [RQ11]
                            end
                            default: begin
                                r_next.branch_valid  = 1'b1;
                                r_next.branch_target = {{(PC_W-FS_HI-ABS_LO_HI-2){1'b0}},
                                    instr_word[FS_HI:0],
                                    r_reg.held_word[ABS_LO_HI:0]}; // [RQ10]
                                r_next.shadow_save = r_reg.held_kind == KIND_CALL &&
                                    r_reg.held_word[CALL_S_POS]; // [RQ7]
                            end
                        endcase
                    end
                end
                default: r_next.phase = ST_FIRST;
            endcase
        end
        // Own flop: the pin never sees an inverter
        r_next.res_to_accum = !r_next.res_to_file; // [RQ2]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg              <= '0;
            r_reg.phase        <= ST_FIRST;
            r_reg.res_to_accum <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata                   = r_reg.prdata;
    assign pready                   = r_reg.pready;
    assign pslverr                  = r_reg.pslverr;
    assign dec_valid                = r_reg.dec_valid;
    assign dec_nop                  = r_reg.dec_nop;
    assign res_to_file              = r_reg.res_to_file;
    assign res_to_accum             = r_reg.res_to_accum;
    assign bank_from_selector       = r_reg.bank_sel;
    assign file_addr                = r_reg.file_addr;
    assign bit_pos                  = r_reg.bit_pos;
    assign literal                  = r_reg.literal;
    assign move_valid               = r_reg.move_valid;
    assign move_src                 = r_reg.move_src;
    assign move_dst                 = r_reg.move_dst;
    assign shadow_save              = r_reg.shadow_save;
    assign shadow_restore           = r_reg.shadow_restore;
    assign branch_valid             = r_reg.branch_valid;
    assign branch_target            = r_reg.branch_target;
    assign idx_valid                = r_reg.idx_valid;
    assign source_index_offset      = r_reg.src_idx;
    assign destination_index_offset = r_reg.dst_idx;
    assign tbl_rd_req               = r_reg.tbl_rd_req;
    assign tbl_wr_req               = r_reg.tbl_wr_req;
    assign tbl_addr                 = r_reg.tbl_addr;
    assign table_byte_latch         = r_reg.latch;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_byte_fields: assert property (first_ok && instr_kind == KIND_BYTE // [RQ1]
        |=> dec_valid && file_addr[F_HI:0] == $past(instr_word[F_HI:0]))
        else $error("byte file address not taken from low byte");
    a_dest_select: assert property (first_ok && instr_kind == KIND_BYTE // [RQ2]
        |=> res_to_accum == !$past(instr_word[D_POS]) && res_to_file != res_to_accum)
        else $error("destination select mismatch");
    a_access_bank: assert property (first_ok && !instr_word[A_POS] // [RQ3]
        |=> file_addr[FILE_W-1:F8_W] == ACCESS_BANK && !bank_from_selector)
        else $error("access bank not forced");
    a_selector_bank: assert property (first_ok && instr_word[A_POS] // [RQ3]
        |=> file_addr[FILE_W-1:F8_W] == $past(r_reg.bank))
        else $error("bank selector not used");

    // Pair words may be apart by idle cycles
    a_move_pair: assert property (instr_valid && r_reg.phase == ST_SECOND // [RQ4]
        && r_reg.held_kind == KIND_MOVE && cifd_is_second(instr_word)
        |=> move_valid && move_src == $past(r_reg.held_word[FS_HI:0])
            && move_dst == $past(instr_word[FS_HI:0]))
        else $error("memory move addresses wrong");

    a_bit_field: assert property (first_ok && instr_kind == KIND_BIT // [RQ5]
        |=> bit_pos == $past(instr_word[BIT_HI:BIT_LO]) && res_to_file)
        else $error("bit position wrong");
    a_literal_byte: assert property (first_ok && instr_kind == KIND_LIT // [RQ6]
        |=> literal == $past(instr_word[LIT_HI:0]) && !branch_valid)
        else $error("literal wrong");
    a_fast_return: assert property (first_ok && instr_kind == KIND_RET // [RQ7]
        |=> shadow_restore == $past(instr_word[RET_S_POS]) && !shadow_save)
        else $error("fast return select ignored");

    a_rel_branch: assert property (first_ok && instr_kind == KIND_BRA_SHORT // [RQ10]
        |=> branch_valid && branch_target == $past(instr_pc)
            + {{(PC_W-BRS_HI-1){$past(instr_word[BRS_HI])}}, $past(instr_word[BRS_HI:0])})
        else $error("relative branch target wrong");
    a_lone_second: assert property (instr_valid && r_reg.phase == ST_FIRST // [RQ12]
        && cifd_is_second(instr_word)
        |=> dec_valid && dec_nop && !move_valid && !branch_valid && !idx_valid)
        else $error("lone second word not a no-operation");

    c_move_done:   cover property (move_valid);
    c_fast_call:   cover property (shadow_save && branch_valid);
    c_table_read:  cover property (tbl_rd_req ##[1:8] tbl_rd_ack);
    c_apb_unmapped: cover property (pready && pslverr);

endmodule : cifd_top

// file: test/cifd_fetch_model.sv
// Fetch-side model that answers table reads with a byte after a set delay
module cifd_fetch_model
    import cifd_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             tbl_rd_req,
    input  wire logic [3:0]       dly,
    input  wire logic [LAT_W-1:0] rd_byte,
    output logic                  tbl_rd_ack,
    output logic      [LAT_W-1:0] tbl_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;
    // ==========================================
    // Idle data toggles so a stale byte never passes for an answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 4'h0;
            tbl_rd_ack <= 1'b0;
            tbl_rd_data <= 8'h00;
        end else begin
            tbl_rd_ack <= 1'b0;
            tbl_rd_data <= ~tbl_rd_data;
            if (tbl_rd_req) cnt_reg <= dly;
            else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
            if (!tbl_rd_req && cnt_reg == 4'h1) begin
                tbl_rd_ack <= 1'b1;
                tbl_rd_data <= rd_byte;
            end
        end
    end
endmodule : cifd_fetch_model

// file: test/cifd_top_tb.sv
// Self-checking bench of the instruction field decoder
module cifd_top_tb;
    import cifd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_valid, tbl_rd_ack;
    logic dec_valid, dec_nop, res_to_accum, res_to_file, move_valid, shadow_restore, shadow_save;
    logic tbl_rd_req, tbl_wr_req, e;
    logic [11:0] paddr, file_addr, move_src, move_dst;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] instr_word;
    cifd_kind_t  instr_kind;
    logic [20:0] instr_pc, branch_target, tbl_addr;
    logic [7:0]  tbl_rd_data, literal, rd_byte;
    logic [6:0]  source_index_offset, destination_index_offset;
    logic [2:0]  bit_pos;
    logic [3:0]  dly;
    int n_mismatch = 0, tests_run = 0;
    typedef struct {logic [15:0] w; cifd_kind_t k; logic [11:0] f; logic r; logic [2:0] b;} row_t;
    row_t rows[5] = '{'{16'h25A3, KIND_BYTE, 12'h5A3, 1'b0, 3'h2},
        '{16'h2612, KIND_BYTE, 12'h012, 1'b1, 3'h3}, '{16'h27FF, KIND_BYTE, 12'h5FF, 1'b1, 3'h3},
        '{16'h8E40, KIND_BIT, 12'h040, 1'b1, 3'h7}, '{16'h0E7F, KIND_LIT, 12'h07F, 1'b1, 3'h7}};
    cifd_top u_cifd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_kind(instr_kind), .instr_pc(instr_pc), .tbl_rd_ack(tbl_rd_ack),
        .tbl_rd_data(tbl_rd_data), .dec_valid(dec_valid), .dec_nop(dec_nop),
        .res_to_accum(res_to_accum), .res_to_file(res_to_file), .bank_from_selector(),
        .file_addr(file_addr), .bit_pos(bit_pos), .literal(literal), .move_valid(move_valid),
        .move_src(move_src), .move_dst(move_dst), .shadow_save(shadow_save),
        .shadow_restore(shadow_restore), .branch_valid(), .branch_target(branch_target),
        .idx_valid(), .source_index_offset(source_index_offset),
        .destination_index_offset(destination_index_offset), .tbl_rd_req(tbl_rd_req),
        .tbl_wr_req(tbl_wr_req), .tbl_addr(tbl_addr), .table_byte_latch());
    cifd_fetch_model u_cifd_fetch_model (.pclk(pclk), .presetn(presetn),
        .tbl_rd_req(tbl_rd_req), .dly(dly), .rd_byte(rd_byte), .tbl_rd_ack(tbl_rd_ack),
        .tbl_rd_data(tbl_rd_data));
    // ==========================================
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            $display("[FAIL] %s expected %h seen %h", s, x, g);
            n_mismatch++;
        end
    endtask : chk
    // Master holds every request signal until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic send(input logic [15:0] w, input cifd_kind_t k);
        @(posedge pclk);
        {instr_valid, instr_word} <= {1'b1, w};
        instr_kind <= k;
        @(posedge pclk);
        instr_valid <= 1'b0;
        #1;
    endtask : send
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, instr_valid, instr_word} = '0;
        {instr_pc, rd_byte, dly} = {21'h000100, 8'h00, 4'h1};
        instr_kind = KIND_OTHER;
        repeat (5) @(posedge pclk);
        chk("res_to_accum", 1, res_to_accum);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, REG_BANK, 32'h5);
        foreach (rows[i]) begin
            send(rows[i].w, rows[i].k);
            chk("file_addr", rows[i].f, file_addr);
            chk("res_to_file", rows[i].r, res_to_file);
            chk("res_to_accum", !rows[i].r, res_to_accum);
            chk("bit_pos", rows[i].b, bit_pos);
            chk("literal", rows[i].w[7:0], literal);
        end
        $display("field rows done");
        send(16'hC123, KIND_MOVE);
        chk("dec_valid", 0, dec_valid);
        send(16'hF456, KIND_MOVE);
        chk("move", {1'b1, 12'h123, 12'h456}, {move_valid, move_src, move_dst});
        send(16'hF0AA, KIND_OTHER);
        chk("dec_nop", 1, dec_nop);
        send(16'hED12, KIND_CALL);
        send(16'hF345, KIND_CALL);
        chk("call", {1'b1, 21'h034512}, {shadow_save, branch_target});
        send(16'h0013, KIND_RET);
        chk("shadow_restore", 1, shadow_restore);
        send(16'h0012, KIND_RET);
        chk("shadow_restore", 0, shadow_restore);
        send(16'hE0FE, KIND_BRA_SHORT);
        chk("rel_target", 21'h0000FE, branch_target);
        send(16'hD7FF, KIND_BRA_LONG);
        chk("long_target", 21'h0000FF, branch_target);
        send(16'hE8C5, KIND_IDX_MOVE);
        send(16'hF0B3, KIND_IDX_MOVE);
        chk("idx", {7'h45, 7'h33}, {source_index_offset, destination_index_offset});
        $display("control words done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, REG_PROGRAM_TABLE_POINTER, 32'h10);
            rd_byte <= 8'h5A + 8'(m);
            dly <= m[0] ? 4'h1 : 4'h2;
            send(16'h0008 | 16'(m), KIND_TBLRD);
            chk("tbl_rd_req", 1, tbl_rd_req);
            chk("tbl_addr", (m == 3) ? 32'h11 : 32'h10, tbl_addr);
            apb(1'b0, REG_PROGRAM_TABLE_POINTER, 32'h0);
            chk("ptr", (m == 0) ? 32'h10 : (m == 2) ? 32'h0F : 32'h11, q);
            apb(1'b0, REG_TBLLAT, 32'h0);
            chk("latch", 32'h5A + m, q);
        end
        send(16'h000C, KIND_TBLWT);
        chk("tbl_wr_req", 1, tbl_wr_req);
        apb(1'b1, REG_PROGRAM_TABLE_POINTER, 32'hFFFFFFFF);
        apb(1'b0, REG_PROGRAM_TABLE_POINTER, 32'h0);
        chk("ptr_width", 32'h001FFFFF, q);
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 1, e);
        chk("unmapped", 0, q);
        $display("table and bus done");
        stop_test();
    end
endmodule : cifd_top_tb
